// [hw/map_switch_consts.svh]
// constants for the map switch controller
// assumes inclusion by the design module only
`ifndef MAP_SWITCH_CONSTS_SVH
`define MAP_SWITCH_CONSTS_SVH
`define TRAP_OPCODE 8'h83
`define STACK_BYTES 3'h5
`define ROM_LOW 13'h0080
`define ROM_HIGH 13'h0FFF
`define MASK_8K 13'h0FFF
`define MASK_2K 13'h07FF
`endif

// [hw/map_switch_pkg.sv]
// types for the map switch controller
// assumes the constants header sits beside it
package map_switch_pkg;
	typedef enum logic {MONITOR_MAP, USER_MAP} map_type;
	typedef enum logic [2:0] {MON, TEMP, RUN, FORCING, STACKING} state_type;
	typedef struct packed {
		logic [12:0] address;
		logic read;
		logic write;
		logic fetch;
	} bus_type;
	typedef struct packed {
		logic go;
		logic tempEnter;
		logic tempLeave;
		logic breakpointSet;
	} command_type;
endpackage

// [hw/emulator_map_switch_control.sv]
// map switch controller between monitor and user memory maps
// assumes the processor bus is synchronous to clock; buttons are debounced
`timescale 1ns/1ps
`include "map_switch_consts.svh"
module emulator_map_switch_control (
	input wire logic clock, // 200 MHz bus clock
	input wire logic resetn, // master/power-on reset, low
	input wire map_switch_pkg::bus_type bus, // processor bus cycle
	input wire logic [7:0] memReadData, // data from memory
	input wire map_switch_pkg::command_type command, // monitor commands
	input wire logic userResetButton, // user reset, high while pressed
	input wire logic abortButton, // abort, high while pressed
	input wire logic mode8k, // 1: 8K map mirror, 0: 2K
	input wire logic protectEnable, // 1: write protect pseudo rom
	output logic userMap, // user map selected
	output logic cpuReset, // processor reset, high
	output logic userIoReset, // user io reset, high
	output logic [7:0] cpuReadData, // data to processor
	output logic [12:0] mappedAddress, // mirrored address
	output logic writeEnable // memory write allowed
);
	import map_switch_pkg::*;
	state_type state_reg, state_next;
	logic ignoreBp_reg, ignoreBp_next;
	logic abortSeen_reg, abortSeen_next;
	logic [2:0] stackCount_reg, stackCount_next;
	logic [7:0] data_next;
	logic [12:0] addr_next;
	logic wen_next, rst_next, isUser, inRom, forceTrap;

	always_comb begin
		state_next = state_reg;
		ignoreBp_next = ignoreBp_reg;
		abortSeen_next = abortSeen_reg & abortButton;
		stackCount_next = stackCount_reg;
		rst_next = 1'b0;
		unique case (state_reg)
			MON: begin
				if (command.go) begin
					state_next = RUN;
					ignoreBp_next = 1'b0;
				end else if (command.tempEnter) begin
					state_next = TEMP;
				end
			end
			TEMP: begin
				if (command.tempLeave)
					state_next = MON;
			end
			RUN: begin
				// a press held from before counts once only
				if (abortButton && !abortSeen_reg) begin
					state_next = FORCING;
					abortSeen_next = 1'b1;
				end else if (bus.fetch && bus.read
					&& memReadData == `TRAP_OPCODE
					&& command.breakpointSet && !ignoreBp_reg) begin
					state_next = STACKING;
					stackCount_next = 3'h0;
				end
			end
			FORCING: begin
				if (bus.fetch && bus.read) begin
					state_next = STACKING;
					stackCount_next = 3'h0;
				end
			end
			STACKING: begin
				// only writes advance the count; reads here are ignored
				if (bus.write)
					stackCount_next = stackCount_reg + 3'h1;
				if (bus.write && stackCount_reg == `STACK_BYTES - 3'h1)
					state_next = MON;
			end
			default: state_next = MON;
		endcase
		// user reset overrides every state, the monitor included
		if (userResetButton) begin
			state_next = RUN;
			ignoreBp_next = 1'b1;
			rst_next = 1'b1;
		end
	end

	always_comb begin
		isUser = state_next != MON;
		addr_next = bus.address & (mode8k ? `MASK_8K : `MASK_2K);
		inRom = addr_next >= `ROM_LOW && addr_next <= `ROM_HIGH;
		wen_next = bus.write && !(isUser && state_next != TEMP && inRom
			&& protectEnable);
		// the flagged fetch must still see the trap opcode, or the
		// processor would load the real opcode and never trap
		forceTrap = state_next == FORCING || (state_reg == FORCING
			&& bus.fetch && bus.read && !userResetButton);
		data_next = forceTrap ? `TRAP_OPCODE : memReadData;
	end

	// every output leaves from a flip-flop, one cycle after sampling
	always_ff @(posedge clock) begin
		if (!resetn) begin
			state_reg <= MON;
			ignoreBp_reg <= 1'b0;
			abortSeen_reg <= 1'b0;
			stackCount_reg <= 3'h0;
			userMap <= 1'b0;
			cpuReset <= 1'b1;
			userIoReset <= 1'b1;
			cpuReadData <= 8'h00;
			mappedAddress <= 13'h0000;
			writeEnable <= 1'b0;
		end else begin
			state_reg <= state_next;
			ignoreBp_reg <= ignoreBp_next;
			abortSeen_reg <= abortSeen_next;
			stackCount_reg <= stackCount_next;
			userMap <= isUser;
			cpuReset <= rst_next;
			userIoReset <= rst_next;
			cpuReadData <= data_next;
			mappedAddress <= addr_next;
			writeEnable <= wen_next;
		end
	end

	property p_user_reset;
		@(posedge clock) disable iff (!resetn)
		userResetButton |=> userMap && cpuReset && userIoReset;
	endproperty
	a_user_reset: assert property (p_user_reset) else $error("user reset");
	property p_abort_mon;
		@(posedge clock) disable iff (!resetn)
		state_reg == MON && !userResetButton && !command.go
			&& !command.tempEnter |=> !userMap;
	endproperty
	a_abort_mon: assert property (p_abort_mon)
		else $error("abort in monitor");
	property p_force;
		@(posedge clock) disable iff (!resetn)
		state_reg == RUN && abortButton && !abortSeen_reg
			&& !userResetButton |=> cpuReadData == `TRAP_OPCODE;
	endproperty
	a_force: assert property (p_force) else $error("opcode not forced");
	property p_stack;
		@(posedge clock) disable iff (!resetn)
		state_reg == STACKING && !bus.write && !userResetButton
			|=> userMap;
	endproperty
	a_stack: assert property (p_stack) else $error("left before stacking");
	property p_ignore;
		@(posedge clock) disable iff (!resetn)
		state_reg == RUN && ignoreBp_reg && !abortButton
			&& !userResetButton |=> state_reg == RUN;
	endproperty
	a_ignore: assert property (p_ignore) else $error("breakpoint taken");
	property p_noswitch;
		@(posedge clock) disable iff (!resetn)
		state_reg == RUN && !command.breakpointSet && !abortButton
			&& !userResetButton |=> userMap;
	endproperty
	a_noswitch: assert property (p_noswitch) else $error("map switched");
	property p_go;
		@(posedge clock) disable iff (!resetn)
		state_reg == MON && command.go |=> userMap;
	endproperty
	a_go: assert property (p_go) else $error("go failed");
	property p_temp;
		@(posedge clock) disable iff (!resetn)
		state_reg == TEMP && !command.tempLeave && !userResetButton
			|=> userMap && state_reg == TEMP;
	endproperty
	a_temp: assert property (p_temp) else $error("temp switch lost");
	property p_protect;
		@(posedge clock) disable iff (!resetn)
		state_reg == RUN && !userResetButton && !abortButton
			&& bus.write && protectEnable
			&& (bus.address & `MASK_2K) >= `ROM_LOW |=> !writeEnable;
	endproperty
	a_protect: assert property (p_protect) else $error("rom written");
	property p_por;
		@(posedge clock) !resetn |=> !userMap && cpuReset && userIoReset;
	endproperty
	a_por: assert property (p_por)
		else $error("reset map wrong");
	// the dropped upper address bits are what puts the vectors on top
	property p_mirror8;
		@(posedge clock) disable iff (!resetn)
		mode8k |=> !mappedAddress[12]
			&& mappedAddress[11:0] == $past(bus.address[11:0]);
	endproperty
	a_mirror8: assert property (p_mirror8)
		else $error("8K mirror wrong");
	property p_mirror2;
		@(posedge clock) disable iff (!resetn)
		!mode8k |=> mappedAddress[12:11] == 2'h0
			&& mappedAddress[10:0] == $past(bus.address[10:0]);
	endproperty
	a_mirror2: assert property (p_mirror2)
		else $error("2K mirror wrong");
	property p_last_byte;
		@(posedge clock) disable iff (!resetn)
		state_reg == STACKING && bus.write && !userResetButton
			&& stackCount_reg == `STACK_BYTES - 3'h1 |=> !userMap;
	endproperty
	a_last_byte: assert property (p_last_byte)
		else $error("stayed after last stack byte");
	property p_force_hold;
		@(posedge clock) disable iff (!resetn)
		state_reg == FORCING && !userResetButton
			|=> cpuReadData == `TRAP_OPCODE;
	endproperty
	a_force_hold: assert property (p_force_hold)
		else $error("trap not held");
	property p_temp_write;
		@(posedge clock) disable iff (!resetn)
		state_reg == TEMP && bus.write && !command.tempLeave
			&& !userResetButton |=> writeEnable;
	endproperty
	a_temp_write: assert property (p_temp_write)
		else $error("temp write blocked");
	// a press already used must not stop the next run
	property p_abort_once;
		@(posedge clock) disable iff (!resetn)
		state_reg == RUN && abortSeen_reg && !userResetButton
			&& !(bus.fetch && bus.read) |=> state_reg == RUN;
	endproperty
	a_abort_once: assert property (p_abort_once)
		else $error("abort used twice");
	c_abort: cover property (@(posedge clock) state_reg == FORCING);
	c_bp: cover property (@(posedge clock) state_reg == STACKING
		&& !abortSeen_reg);
	c_reset: cover property (@(posedge clock) userResetButton);
	c_temp: cover property (@(posedge clock) state_reg == TEMP && bus.write);
	c_ignored: cover property (@(posedge clock) state_reg == RUN
		&& ignoreBp_reg && bus.fetch);
endmodule // emulator_map_switch_control

// [tb/cpu_bus_model.sv]
// processor bus model: one bus cycle per clock
// assumes the controller samples bus and data on rising edges
`timescale 1ns/1ps
module cpu_bus_model (
	input wire logic clock, // bus clock
	output map_switch_pkg::bus_type bus, // bus cycle
	output logic [7:0] memReadData // memory data
);
	import map_switch_pkg::*;
	initial begin
		bus = '0;
		memReadData = 8'hA5;
	end
	task cycle(input logic [12:0] a, input logic r, w, f, input logic [7:0] d);
		@(posedge clock);
		#1;
		bus = '{address: a, read: r, write: w, fetch: f};
		// data not held outside reads, so flip it to avoid lucky matches
		memReadData = r ? d : ~memReadData;
	endtask
	task stack_regs(input int n);
		for (int i = 0; i < n; i++)
			cycle(13'h007F - 13'(i), 1'b0, 1'b1, 1'b0, 8'h00);
	endtask
endmodule // cpu_bus_model

// [tb/tb_top.sv]
// self-checking bench for the map switch controller
// assumes the bus model issues cycles; this bench drives the rest
`timescale 1ns/1ps
module tb_top;
	import map_switch_pkg::*;
	logic clock = 0, resetn = 0, userResetButton = 0, abortButton = 0;
	logic mode8k = 1, protectEnable = 1, userMap, cpuReset, userIoReset;
	logic writeEnable;
	logic [7:0] memReadData, cpuReadData;
	logic [12:0] mappedAddress;
	bus_type bus;
	command_type command = '0;
	int failures = 0, tests_run = 0, cycles = 0;
	always #2.5 clock = ~clock;
	cpu_bus_model i_cpu_bus_model (.clock(clock), .bus(bus),
		.memReadData(memReadData));
	emulator_map_switch_control i_emulator_map_switch_control (
		.clock(clock), .resetn(resetn), .bus(bus),
		.memReadData(memReadData), .command(command),
		.userResetButton(userResetButton), .abortButton(abortButton),
		.mode8k(mode8k), .protectEnable(protectEnable), .userMap(userMap),
		.cpuReset(cpuReset), .userIoReset(userIoReset),
		.cpuReadData(cpuReadData), .mappedAddress(mappedAddress),
		.writeEnable(writeEnable));
	task chk(input string n, input logic [12:0] s, e);
		tests_run++;
		if (s !== e) begin
			failures++;
			$display("[ERR] %s expected %h seen %h", n, e, s);
		end
	endtask
	task give_verdict;
		if (failures == 0 && tests_run > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task step(input logic [12:0] a, input logic r, w, f, input logic [7:0] d);
		i_cpu_bus_model.cycle(a, r, w, f, d);
	endtask
	task idle(input int n);
		repeat (n) step(13'h0000, 0, 0, 0, 8'h00);
	endtask
	task go_user;
		command.go = 1;
		idle(1);
		command.go = 0;
		chk("map go", userMap, 1);
	endtask
	task back(input int n, input logic e);
		i_cpu_bus_model.stack_regs(n);
		idle(2);
		chk("map back", userMap, e);
	endtask
	task temp_access;
		command.tempEnter = 1;
		idle(1);
		command.tempEnter = 0;
		chk("map temp", userMap, 1);
		step(13'h0100, 0, 1, 0, 8'h00);
		idle(1);
		chk("we temp", writeEnable, 1);
		command.tempLeave = 1;
		idle(1);
		command.tempLeave = 0;
		chk("map leave", userMap, 0);
	endtask
	task breakpoint_trap;
		go_user;
		step(13'h0100, 0, 1, 0, 8'h00);
		step(13'h1FF6, 1, 0, 0, 8'h5A);
		chk("we rom", writeEnable, 0);
		step(13'h1FF6, 1, 0, 0, 8'h5A);
		chk("addr 8K", mappedAddress, 13'h0FF6);
		mode8k = 0;
		step(13'h0050, 0, 1, 0, 8'h00);
		chk("addr 2K", mappedAddress, 13'h07F6);
		step(13'h0200, 1, 0, 1, 8'h83);
		chk("we ram", writeEnable, 1);
		idle(1);
		chk("map swi", userMap, 1);
		command.breakpointSet = 1;
		step(13'h0202, 1, 0, 1, 8'h83);
		back(4, 1);
		back(1, 0);
		command.breakpointSet = 0;
		mode8k = 1;
	endtask
	task abort_run;
		abortButton = 1;
		step(13'h0300, 1, 0, 0, 8'h11);
		step(13'h0301, 1, 0, 0, 8'h22);
		chk("data mon", cpuReadData, 8'h11);
		chk("map mon", userMap, 0);
		abortButton = 0;
		go_user;
		abortButton = 1;
		step(13'h0302, 1, 0, 0, 8'h33);
		step(13'h0303, 1, 0, 0, 8'h44);
		step(13'h0304, 1, 0, 1, 8'h55);
		chk("data force", cpuReadData, 8'h83);
		step(13'h0306, 1, 0, 0, 8'h66);
		chk("data fetch", cpuReadData, 8'h83);
		idle(1);
		chk("data after", cpuReadData, 8'h66);
		back(5, 0);
		// abort still held from the last press: a new run must not stop
		go_user;
		idle(2);
		chk("map held", userMap, 1);
		abortButton = 0;
	endtask
	task user_reset_run;
		userResetButton = 1;
		idle(1);
		userResetButton = 0;
		chk("map ur", userMap, 1);
		chk("cpu ur", cpuReset, 1);
		chk("io ur", userIoReset, 1);
		command.breakpointSet = 1;
		step(13'h0400, 1, 0, 1, 8'h83);
		chk("cpu end", cpuReset, 0);
		back(5, 1);
		command.breakpointSet = 0;
		abortButton = 1;
		step(13'h0405, 1, 0, 1, 8'h01);
		abortButton = 0;
		back(5, 0);
	endtask
	task master_reset_run;
		go_user;
		resetn = 0;
		idle(1);
		chk("map mr", userMap, 0);
		chk("cpu mr", cpuReset, 1);
		chk("io mr", userIoReset, 1);
		resetn = 1;
		idle(1);
		chk("cpu run", cpuReset, 0);
		go_user;
	endtask
	always @(posedge clock) begin
		cycles++;
		if (cycles == 2000) begin
			failures++;
			give_verdict;
		end
	end
	initial begin
		idle(6);
		chk("map por", userMap, 0);
		chk("cpu por", cpuReset, 1);
		chk("io por", userIoReset, 1);
		resetn = 1;
		temp_access;
		breakpoint_trap;
		abort_run;
		user_reset_run;
		master_reset_run;
		give_verdict;
	end
endmodule // tb_top
